//--- qpc_defs.svh
// Constants for the quadrature pulse counter with presets
// How it works
// - Counter mode: input A pulses, B direction, C enable, D reset.
// - Direction input unused or idle: count up.
// - Direction input unused: software direction bit 10 of discrete command.
// - Enable input unused or idle: counting enabled.
// - Enable input unused: software enable bit 9 of discrete command.
// - Reset input held: accumulator held at lower limit, counting inhibited.
// - Reset input unused: software reset bit 19 of discrete command.
// - Encoder mode: A and B quadrature channels, C marker pulse.
// - Homing active with limit switch: next marker loads home value.
// - Encoder rate one, two or four per cycle; counter mode single only.
// - Each input has a selectable filter limiting response to 100 Hz.
// - 24-bit accumulator built by sampling an 8-bit hardware counter.
// - Accumulator is signed, -8388608 to +8388607.
// - Counting up past upper limit wraps to lower limit.
// - Counting down past lower limit wraps to upper limit.
// - Compare result is accumulator >= preset, inverted by command 35 sense.
// - Output on when compare result true and output enabled.
// - Latched output stays on until unlatched and conditions false.
// - Eight internal presets compared, results returned to CPU.
// - CPU exchange uses 32-bit command and return words.
// - Optional standalone run once presets loaded, whatever CPU state.
// - Power loss sets a reload-needed status bit.
// - One command per write; command number in low byte.
`ifndef QPC_DEFS_SVH
`define QPC_DEFS_SVH

`define QPC_CLK_HZ 100000000
`define QPC_FILT_HZ 100
`define QPC_FILT_CYC (`QPC_CLK_HZ / (2 * `QPC_FILT_HZ))
`define QPC_SAMPLE_CYC 16

`define QPC_OFS_CMD 8'h00
`define QPC_OFS_RET 8'h04

`define QPC_CMD_DISC 8'h00
`define QPC_CMD_LOWER 8'h01
`define QPC_CMD_UPPER 8'h02
`define QPC_CMD_HOME 8'h03
`define QPC_CMD_DONE 8'h04
`define QPC_CMD_PRESET 5'h02
`define QPC_CMD_SENSE 8'h23
`define QPC_CMD_SEL_ACC 8'h30
`define QPC_CMD_SEL_STAT 8'h31
`define QPC_ERR_CODE 8'hee

`define QPC_D_ENA_OFF 0
`define QPC_D_DOWN 1
`define QPC_D_OEN 2
`define QPC_D_LATCH 6
`define QPC_D_RESET 10
`define QPC_D_HOMING 11

`define QPC_LOWER_RST 24'h800000
`define QPC_UPPER_RST 24'h7fffff

`endif

//--- qpc_pkg.sv
// Types for the quadrature pulse counter
`default_nettype none
package qpc_pkg;
    typedef enum logic [1:0] {
        single_rate_count,
        double_rate_count,
        quadruple_rate_count
    } qpc_rate_t;
    typedef enum logic {
        qpc_ret_acc,
        qpc_ret_stat
    } qpc_ret_t;
    typedef logic signed [23:0] qpc_count_t;
endpackage
`default_nettype wire

//--- qpc_filt.sv
// Input debounce filter
`default_nettype none
module qpc_filt #(
    parameter int unsigned STABLE_CYC = 500000
) (
    input wire logic clk_i,   // Clock
    input wire logic rst_b_i, // Synchronised reset, active low
    input wire logic en_i,    // Filter selected
    input wire logic raw_i,   // Raw input level
    output logic filt_o       // Filtered level
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    logic [CW-1:0] cnt_r;
    logic state_r;

    initial begin
        if (STABLE_CYC < 1) begin
            $error("STABLE_CYC must be at least 1");
        end
    end

    // Level changes only after standing for a full half period
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= 1'b0;
            cnt_r <= '0;
        end else if (!en_i || raw_i == state_r) begin
            state_r <= en_i ? state_r : raw_i;
            cnt_r <= '0;
        end else if (cnt_r == CW'(STABLE_CYC - 1)) begin
            state_r <= raw_i;
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign filt_o = state_r;
endmodule // qpc_filt
`default_nettype wire

//--- qpc_top.sv
// Quadrature pulse counter with presets, limits and outputs
`include "qpc_defs.svh"
`default_nettype none
module qpc_top
    import qpc_pkg::*;
#(
    parameter int unsigned FILT_CYC = `QPC_FILT_CYC,
    parameter int unsigned SAMPLE_CYC = `QPC_SAMPLE_CYC,
    parameter int unsigned N_PRESET = 8,
    parameter int unsigned N_OUT = 4
) (
    input wire logic clk_i,              // 100 MHz clock
    input wire logic rst_b_i,            // Reset, active low
    input wire logic [7:0] addr_i,       // Register address
    input wire logic [31:0] wdata_i,     // Write data
    input wire logic wr_i,               // Write strobe
    input wire logic rd_i,               // Read strobe
    output logic [31:0] rdata_o,         // Read data, cycle after rd_i
    input wire logic [3:0] in_i,         // Field inputs A..D
    input wire logic [3:0] in_used_i,    // Input wired and enabled
    input wire logic [3:0] filt_en_i,    // Debounce filter select
    input wire logic enc_mode_i,         // 1 encoder mode, 0 counter mode
    input wire logic [1:0] rate_sel_i,   // Quadrature rate select
    input wire logic standalone_i,       // Run regardless of CPU state
    input wire logic cpu_run_i,          // CPU is running
    input wire logic power_lost_i,       // Field or rack power lost
    output logic [N_OUT-1:0] out_o,      // Output level (sink low)
    output logic [N_OUT-1:0] out_oe_o,   // Output sinking
    output logic reload_o                // Configuration must be reloaded
);
    initial begin
        if (SAMPLE_CYC < 1 || SAMPLE_CYC > 127) begin
            $error("SAMPLE_CYC must be 1..127");
        end
        if (N_PRESET > 8 || N_OUT > N_PRESET || N_OUT > 4) begin
            $error("At most 8 presets and 4 outputs");
        end
        if (FILT_CYC < 1) begin
            $error("FILT_CYC must be at least 1");
        end
    end

    function automatic logic ge_sgn(input qpc_count_t a, input qpc_count_t b);
        ge_sgn = (a >= b);
    endfunction

    // Reset release
    logic rst_s1_r;
    logic rst_b_s;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_r <= 1'b0;
            rst_b_s <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_s <= rst_s1_r;
        end
    end

    // Input filtering; an unused input reads inactive
    logic [3:0] filt;
    logic [3:0] prev_r;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            qpc_filt #(.STABLE_CYC(FILT_CYC)) u_filt (
                .clk_i(clk_i),
                .rst_b_i(rst_b_s),
                .en_i(filt_en_i[gi]),
                .raw_i(in_i[gi] & in_used_i[gi]),
                .filt_o(filt[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            prev_r <= 4'h0;
        end else begin
            prev_r <= filt;
        end
    end

    wire [3:0] rise = filt & ~prev_r;
    wire [3:0] edg = filt ^ prev_r;

    // Configuration state written by commands
    logic [23:0] disc_r;
    qpc_count_t lower_r;
    qpc_count_t upper_r;
    qpc_count_t home_r;
    qpc_count_t preset_r [N_PRESET];
    logic [N_OUT-1:0] sense_r;
    qpc_ret_t ret_sel_r;
    logic loaded_r;
    logic reload_r;
    logic err_r;
    logic [7:0] err_cmd_r;

    wire cmd_wr = wr_i && addr_i == `QPC_OFS_CMD;
    wire [7:0] cmd = wdata_i[7:0];
    wire [23:0] cdata = wdata_i[31:8];
    wire is_disc = cmd == `QPC_CMD_DISC;
    wire is_lower = cmd == `QPC_CMD_LOWER;
    wire is_upper = cmd == `QPC_CMD_UPPER;
    wire is_home = cmd == `QPC_CMD_HOME;
    wire is_done = cmd == `QPC_CMD_DONE;
    wire is_pre = cmd[7:3] == `QPC_CMD_PRESET && 32'(cmd[2:0]) < N_PRESET;
    wire is_sense = cmd == `QPC_CMD_SENSE;
    wire is_sel_acc = cmd == `QPC_CMD_SEL_ACC;
    wire is_sel_st = cmd == `QPC_CMD_SEL_STAT;
    wire known = is_disc | is_lower | is_upper | is_home | is_done
        | is_pre | is_sense | is_sel_acc | is_sel_st;
    wire ret_rd = rd_i && addr_i == `QPC_OFS_RET;

    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            disc_r <= 24'h000000;
            lower_r <= `QPC_LOWER_RST;
            upper_r <= `QPC_UPPER_RST;
            home_r <= 24'h000000;
            sense_r <= '0;
            ret_sel_r <= qpc_ret_acc;
        end else if (cmd_wr) begin
            if (is_disc) begin
                disc_r <= cdata;
            end
            if (is_lower) begin
                lower_r <= cdata;
            end
            if (is_upper) begin
                upper_r <= cdata;
            end
            if (is_home) begin
                home_r <= cdata;
            end
            if (is_sense) begin
                sense_r <= cdata[N_OUT-1:0];
            end
            if (is_sel_acc) begin
                ret_sel_r <= qpc_ret_acc;
            end
            if (is_sel_st) begin
                ret_sel_r <= qpc_ret_stat;
            end
        end
    end

    generate
        for (gi = 0; gi < N_PRESET; gi++) begin : g_pre
            always_ff @(posedge clk_i or negedge rst_b_s) begin
                if (!rst_b_s) begin
                    preset_r[gi] <= 24'h000000;
                end else if (cmd_wr && is_pre && 32'(cmd[2:0]) == gi) begin
                    preset_r[gi] <= cdata;
                end
            end
        end
    endgenerate

    // Status flags; power loss wins over a preset load or done, a new error over a read
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            loaded_r <= 1'b0;
            reload_r <= 1'b0;
            err_r <= 1'b0;
            err_cmd_r <= 8'h00;
        end else begin
            if (power_lost_i) begin
                loaded_r <= 1'b0;
            end else if (cmd_wr && is_pre) begin
                loaded_r <= 1'b1;
            end
            if (power_lost_i) begin
                reload_r <= 1'b1;
            end else if (cmd_wr && is_done) begin
                reload_r <= 1'b0;
            end
            if (cmd_wr && !known) begin
                err_r <= 1'b1;
                err_cmd_r <= cmd;
            end else if (ret_rd) begin
                err_r <= 1'b0;
            end
        end
    end

    // Running: CPU active, or standalone after presets loaded
    wire active = cpu_run_i || (standalone_i && loaded_r);

    // Counter mode controls
    wire cnt_down = in_used_i[1] ? filt[1] : disc_r[`QPC_D_DOWN];
    wire cnt_off = in_used_i[2] ? filt[2] : disc_r[`QPC_D_ENA_OFF];
    wire rst_req = in_used_i[3] ? filt[3] : disc_r[`QPC_D_RESET];
    wire rst_hold = !enc_mode_i && rst_req;

    // Quadrature decoding
    qpc_rate_t rate;
    assign rate = enc_mode_i ? qpc_rate_t'(rate_sel_i) : single_rate_count;
    wire qa = filt[0];
    wire qb = filt[1];
    logic q_step;
    logic q_up;
    always_comb begin
        q_step = 1'b0;
        q_up = 1'b0;
        unique case (rate)
            double_rate_count: begin
                q_step = edg[0];
                q_up = qa != qb;
            end
            quadruple_rate_count: begin
                q_step = edg[0] | edg[1];
                q_up = edg[0] ? (qa != qb) : (qa == qb);
            end
            default: begin
                q_step = rise[0];
                q_up = !qb;
            end
        endcase
    end

    wire step = active && (enc_mode_i ? q_step
        : rise[0] && !cnt_off && !rst_hold);
    wire step_up = enc_mode_i ? q_up : !cnt_down;

    // Homing: one load per activation of the homing command
    logic homed_r;
    wire homing = enc_mode_i && disc_r[`QPC_D_HOMING];
    wire home_ld = homing && !homed_r && filt[3] && rise[2];
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            homed_r <= 1'b0;
        end else if (!homing) begin
            homed_r <= 1'b0;
        end else if (home_ld) begin
            homed_r <= 1'b1;
        end
    end

    // Fast 8-bit counter, sampled into the accumulator
    logic [7:0] hw_r;
    logic [7:0] last_r;
    logic [6:0] tick_r;
    qpc_count_t acc_r;
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            hw_r <= 8'h00;
        end else if (step) begin
            hw_r <= step_up ? hw_r + 8'h01 : hw_r - 8'h01;
        end
    end

    wire tick = tick_r == 7'(SAMPLE_CYC - 1);
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            tick_r <= 7'h00;
        end else begin
            tick_r <= tick ? 7'h00 : tick_r + 7'h01;
        end
    end

    // Wrap between limits; a sample moves less than the limit span
    // SAMPLE_CYC under 128 keeps one sample's change inside the signed delta
    wire signed [7:0] delta = signed'(hw_r - last_r);
    wire signed [25:0] sum = 26'(acc_r) + 26'(delta);
    wire signed [25:0] up26 = 26'(upper_r);
    wire signed [25:0] lo26 = 26'(lower_r);
    wire signed [25:0] span = up26 - lo26 + 26'sh1;
    wire over = sum > up26;
    wire under = sum < lo26;
    wire signed [25:0] wrapped = over ? sum - span
        : under ? sum + span : sum;
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            acc_r <= `QPC_LOWER_RST;
            last_r <= 8'h00;
        end else if (rst_hold) begin
            acc_r <= lower_r;
            last_r <= hw_r;
        end else if (home_ld) begin
            acc_r <= home_r;
            last_r <= hw_r;
        end else if (tick) begin
            acc_r <= wrapped[23:0];
            last_r <= hw_r;
        end
    end

    // Preset comparisons
    logic [7:0] pre_ge;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_cmp
            if (gi < N_PRESET) begin : g_on
                assign pre_ge[gi] = ge_sgn(acc_r, preset_r[gi]);
            end else begin : g_off
                assign pre_ge[gi] = 1'b0;
            end
        end
    endgenerate

    // Outputs, with enable and latch
    wire [N_OUT-1:0] cmp_res = pre_ge[N_OUT-1:0] ^ sense_r;
    wire [N_OUT-1:0] oen = disc_r[`QPC_D_OEN +: N_OUT];
    wire [N_OUT-1:0] latch = disc_r[`QPC_D_LATCH +: N_OUT];
    logic [N_OUT-1:0] out_r;
    wire [N_OUT-1:0] out_nxt = active ? (cmp_res & oen)
        | (latch & out_r) : '0;
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign out_oe_o = out_r;
    assign out_o = '0;
    assign reload_o = reload_r;

    // Return word
    wire [31:0] ret_acc = {acc_r, pre_ge};
    wire [31:0] ret_st = {16'h0000, homed_r, loaded_r, enc_mode_i, reload_r,
        4'(out_r), 8'h00};
    wire [31:0] ret_err = {16'h0000, err_cmd_r, `QPC_ERR_CODE};
    wire [31:0] ret_word = err_r ? ret_err
        : ret_sel_r == qpc_ret_stat ? ret_st : ret_acc;
    wire [31:0] rd_mux = addr_i == `QPC_OFS_RET ? ret_word
        : addr_i == `QPC_OFS_CMD ? {disc_r, 8'h00} : 32'h0000_0000;

    // Read data stand for one cycle and are zero otherwise
    logic [31:0] rdata_r;
    always_ff @(posedge clk_i or negedge rst_b_s) begin
        if (!rst_b_s) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_r;
endmodule // qpc_top
`default_nettype wire

//--- qpc_sva.sv
// Port checker for the quadrature pulse counter
`default_nettype none
module qpc_sva (
    input wire logic clk_i,          // Clock
    input wire logic rst_b_i,        // Reset, active low
    input wire logic [7:0] addr_i,   // Address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i,           // Write strobe
    input wire logic rd_i,           // Read strobe
    input wire logic [31:0] rdata_o, // Read data
    input wire logic standalone_i,   // Standalone run
    input wire logic cpu_run_i,      // CPU running
    input wire logic power_lost_i,   // Power lost
    input wire logic [3:0] out_oe_o, // Outputs on
    input wire logic reload_o        // Reload flag
);
    logic [23:0] disc_r;
    wire [7:0] cmd = wdata_i[7:0];
    wire cmd_wr = wr_i && addr_i == 8'h00;
    wire bad = !(cmd <= 8'h04 || cmd[7:3] == 5'h02 || cmd == 8'h23 || cmd[7:1] == 7'h18);
    // Shadow of the discrete word, to know enables and latches
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) disc_r <= 24'h0;
        else if (cmd_wr && cmd == 8'h00) disc_r <= wdata_i[31:8];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not idle");
    a_unmapped_zero: assert property (rd_i && addr_i != 8'h00 && addr_i != 8'h04 |=>
        rdata_o == 32'h0) else $error("unmapped read not zero");
    a_reload_set: assert property (power_lost_i |-> ##[1:3] reload_o)
        else $error("reload flag not set");
    a_reload_keep: assert property (reload_o && !(cmd_wr && cmd == 8'h04) |=> reload_o)
        else $error("reload flag dropped");
    a_out_dark: assert property ((!cpu_run_i && !standalone_i) [*2] |-> out_oe_o == 4'h0)
        else $error("output on while inactive");
    a_disc_back: assert property (cmd_wr && cmd == 8'h00 ##1 rd_i && addr_i == 8'h00 |=>
        rdata_o == {$past(wdata_i[31:8], 2), 8'h00}) else $error("discrete word lost");
    a_latch_hold: assert property (disc_r[6] && out_oe_o[0] && cpu_run_i |=> out_oe_o[0])
        else $error("latched output dropped");
    a_enable_gate: assert property (!disc_r[2] && !disc_r[6] |=> !out_oe_o[0])
        else $error("disabled output on");
    a_err_code: assert property (cmd_wr && bad ##1 rd_i && addr_i == 8'h04 |=>
        rdata_o == {16'h0, $past(wdata_i[7:0], 2), 8'hee}) else $error("error code wrong");
endmodule // qpc_sva
bind qpc_top qpc_sva u_sva (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .standalone_i, .cpu_run_i, .power_lost_i, .out_oe_o, .reload_o);
`default_nettype wire

//--- qpc_cpu_model.sv
// Controller model: sends command words and fetches return words
`include "qpc_defs.svh"
`default_nettype none
module qpc_cpu_model
    import qpc_pkg::*;
#(
    parameter int unsigned GAP_CYC = 600000 // Spacing between exchanges
) (
    input wire logic clk_i,          // Clock
    input wire logic [31:0] rdata_i, // Return word
    output logic [7:0] addr_o,       // Address
    output logic [31:0] wdata_o,     // Command word
    output logic wr_o,               // Write strobe
    output logic rd_o                // Read strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Ends at a clock edge so a fetch can follow with no gap
    task automatic send(input logic [7:0] c, input logic [23:0] d);
        repeat (GAP_CYC) @(posedge clk_i);
        @(posedge clk_i);
        addr_o <= `QPC_OFS_CMD;
        wdata_o <= {d, c};
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~{d, c};
    endtask
    task automatic fetch(input logic [7:0] a, output logic [31:0] v);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        v = rdata_i;
    endtask
    task automatic set_limits(input qpc_count_t lo, input qpc_count_t hi);
        send(`QPC_CMD_LOWER, lo);
        send(`QPC_CMD_UPPER, (hi - lo > 24'sd128) ? hi : lo + 24'sd129);
    endtask
endmodule // qpc_cpu_model
`default_nettype wire

//--- qpc_tb.sv
// Self-checking bench for the quadrature pulse counter
`include "qpc_defs.svh"
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module testbench
    import qpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0, rst_b_i = 1'b0, enc_mode_i = 1'b0, standalone_i = 1'b0;
    logic cpu_run_i = 1'b1, power_lost_i = 1'b0;
    logic [3:0] in_i = 4'h0, in_used_i = 4'h0, filt_en_i = 4'h0;
    logic [1:0] rate_sel_i = 2'h0;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, w;
    logic wr_i, rd_i, reload_o;
    logic [3:0] out_o, out_oe_o;
    logic [7:0] ge;
    qpc_count_t lo, hi, exp_acc, pv;
    int mismatches = 0, num_checks = 0, n, seed;
    qpc_top #(.FILT_CYC(4)) dut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .in_i, .in_used_i, .filt_en_i, .enc_mode_i, .rate_sel_i, .standalone_i,
        .cpu_run_i, .power_lost_i, .out_o, .out_oe_o, .reload_o);
    qpc_cpu_model #(.GAP_CYC(2)) cpu (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    function automatic qpc_count_t wrap(input qpc_count_t a, input int d);
        int v = int'(a) + d;
        if (v > int'(hi)) v -= int'(hi) - int'(lo) + 1;
        else if (v < int'(lo)) v += int'(hi) - int'(lo) + 1;
        return qpc_count_t'(v);
    endfunction
    task automatic pulse(input int c, input int wid = 10);
        repeat (c) begin
            in_i[0] <= 1'b1;
            tick(wid);
            in_i[0] <= 1'b0;
            tick(10);
        end
    endtask
    // Phase steps as {B, A}; forward has A leading B
    task automatic quad(input int c, input bit fwd);
        logic [1:0] f [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
        logic [1:0] r [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
        for (int i = 0; i < 4 * c; i++) begin
            in_i[1:0] <= fwd ? f[i % 4] : r[i % 4];
            tick(10);
        end
    endtask
    task automatic chk_acc(input string nm);
        tick(60);
        cpu.send(`QPC_CMD_SEL_ACC, 24'h0);
        cpu.fetch(`QPC_OFS_RET, w);
        `CHK(nm, exp_acc, w[31:8])
    endtask
    task automatic done(input string t);
        $display("test %s done", t);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        tick(80000);
        mismatches++;
        close_out();
    end
    initial begin
        seed = $urandom(32'hb04218a1);
        tick(3);
        rst_b_i <= 1'b1;
        filt_en_i <= 4'($urandom);
        tick(4);
        `CHK("reload", 1'b0, reload_o)
        cpu.fetch(8'h20, w);
        `CHK("unmapped", 32'h0, w)
        lo = -qpc_count_t'($urandom_range(1000));
        hi = lo + qpc_count_t'($urandom_range(250, 150));
        cpu.set_limits(lo, hi);
        cpu.send(`QPC_CMD_DISC, 24'h400);
        cpu.fetch(`QPC_OFS_CMD, w);
        `CHK("disc", 32'h00040000, w)
        cpu.send(`QPC_CMD_DISC, 24'h0);
        exp_acc = lo;
        chk_acc("soft reset");
        in_used_i <= 4'h1;
        rate_sel_i <= 2'h2;
        n = $urandom_range(30, 5);
        pulse(n);
        exp_acc = wrap(exp_acc, n);
        chk_acc("count up");
        filt_en_i <= 4'h1;
        pulse(6, 2);
        chk_acc("filter on");
        filt_en_i <= 4'h0;
        pulse(6, 2);
        exp_acc = wrap(exp_acc, 6);
        chk_acc("filter off");
        filt_en_i <= 4'($urandom);
        n = hi - exp_acc + 2;
        pulse(n);
        exp_acc = wrap(exp_acc, n);
        chk_acc("wrap up");
        cpu.send(`QPC_CMD_DISC, 24'h002);
        n = exp_acc - lo + 3;
        pulse(n);
        exp_acc = wrap(exp_acc, -n);
        chk_acc("wrap down");
        cpu.send(`QPC_CMD_DISC, 24'h003);
        pulse(7);
        chk_acc("soft disable");
        cpu.send(`QPC_CMD_DISC, 24'h0);
        in_used_i <= 4'hf;
        in_i[1] <= 1'b1;
        tick(20);
        pulse(4);
        exp_acc = wrap(exp_acc, -4);
        chk_acc("pin down");
        in_i[2] <= 1'b1;
        tick(20);
        pulse(4);
        chk_acc("pin disable");
        in_i[3:1] <= 3'h4;
        tick(20);
        pulse(3);
        exp_acc = lo;
        chk_acc("pin reset");
        in_i[3] <= 1'b0;
        done("counter");
        enc_mode_i <= 1'b1;
        in_used_i <= 4'h3;
        for (int r = 0; r < 4; r++) begin
            rate_sel_i <= 2'(r);
            quad(3, 1'b1);
            exp_acc = wrap(exp_acc, 3 << (r % 3));
            chk_acc("quad fwd");
            quad(2, 1'b0);
            exp_acc = wrap(exp_acc, -(2 << (r % 3)));
            chk_acc("quad rev");
        end
        exp_acc = lo + 24'sd60;
        cpu.send(`QPC_CMD_HOME, exp_acc);
        in_used_i <= 4'hf;
        rate_sel_i <= 2'h2;
        in_i[3] <= 1'b1;
        cpu.send(`QPC_CMD_DISC, 24'h800);
        tick(20);
        in_i[2] <= 1'b1;
        tick(10);
        in_i[3:2] <= 2'h0;
        tick(40);
        quad(2, 1'b1);
        exp_acc = wrap(exp_acc, 8);
        chk_acc("home");
        cpu.send(`QPC_CMD_DISC, 24'h0);
        done("encoder");
        for (int k = 0; k < 8; k++) begin
            pv = exp_acc + qpc_count_t'($urandom_range(20)) - 24'sd10;
            ge[k] = exp_acc >= pv;
            cpu.send(8'h10 + 8'(k), pv);
        end
        chk_acc("presets");
        `CHK("compare", ge, w[7:0])
        cpu.send(`QPC_CMD_DISC, 24'h03c);
        tick(5);
        `CHK("outputs", ge[3:0], out_oe_o)
        `CHK("sink level", 4'h0, out_o)
        cpu.send(`QPC_CMD_SENSE, 24'h00f);
        tick(5);
        `CHK("sense", ~ge[3:0], out_oe_o)
        cpu.send(`QPC_CMD_DISC, 24'h3c0);
        tick(5);
        `CHK("latched", ~ge[3:0], out_oe_o)
        cpu.send(`QPC_CMD_DISC, 24'h0);
        tick(5);
        `CHK("unlatched", 4'h0, out_oe_o)
        cpu.send(`QPC_CMD_DISC, 24'h03c);
        cpu_run_i <= 1'b0;
        tick(5);
        `CHK("cpu stop", 4'h0, out_oe_o)
        standalone_i <= 1'b1;
        tick(5);
        `CHK("standalone", ~ge[3:0], out_oe_o)
        cpu_run_i <= 1'b1;
        standalone_i <= 1'b0;
        done("outputs");
        n = $urandom_range(15, 5);
        cpu.send(8'(n), 24'($urandom));
        cpu.fetch(`QPC_OFS_RET, w);
        `CHK("error", {16'h0, 8'(n), 8'hee}, w)
        power_lost_i <= 1'b1;
        tick(2);
        power_lost_i <= 1'b0;
        tick(2);
        `CHK("power", 1'b1, reload_o)
        cpu.send(`QPC_CMD_SEL_STAT, 24'h0);
        cpu.fetch(`QPC_OFS_RET, w);
        `CHK("status", {16'h0, 4'h3, ~ge[3:0], 8'h00}, w)
        cpu.send(`QPC_CMD_DONE, 24'h0);
        tick(2);
        `CHK("reloaded", 1'b0, reload_o)
        done("status");
        close_out();
    end
endmodule // testbench
`default_nettype wire
